// [ipm_pkg.sv]
// Shared constants for the indirect PHY management engine and its far end.
// Assumes one 200 MHz clock (pclk) for both ends.
package ipm_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MDC_HALF_NS = 200;
  localparam int MDC_HALF_CYC = (MDC_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] MDC_HALF_LAST = 8'(MDC_HALF_CYC - 1);

  localparam logic [11:0] OFS_DATA = 12'h0a4;
  localparam logic [11:0] OFS_ACCESS = 12'h0a8;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [4:0] TGT_RST = 5'h00;
  localparam logic [4:0] RIDX_RST = 5'h00;
  localparam logic DIR_RST = 1'b0;
  localparam logic BUSY_RST = 1'b0;
  localparam int ACC_BUSY_BIT = 0;
  localparam int ACC_DIR_BIT = 1;
  localparam int ACC_RIDX_LSB = 6;
  localparam int ACC_TGT_LSB = 11;

  localparam logic [31:0] PREAMBLE = 32'hffff_ffff;
  localparam logic [1:0] ST_CODE = 2'h1;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] TA_WR = 2'h2;
  localparam logic [1:0] TA_RD = 2'h3;
  localparam logic [15:0] NO_ANSWER = 16'hffff;
  localparam logic [5:0] IDX_TA_FIRST = 6'h2e;
  localparam logic [5:0] IDX_DATA_FIRST = 6'h30;
  localparam logic [5:0] IDX_LAST = 6'h3f;
  localparam logic [5:0] PRE_CNT = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0b;
  localparam logic [5:0] TAIL_LAST = 6'h11;
endpackage

// [ipm_mgmt_if.sv]
// Management link between the access engine and the PHY register logic.
// Assumes a pull-up: the line reads 1 while nobody drives it.
`timescale 1ns/1ps
interface ipm_mgmt_if;
  logic mdc;
  logic dev_mdio_o;
  logic dev_mdio_oe;
  logic phy_mdio_o;
  logic phy_mdio_oe;
  logic mdio;

  assign mdio = dev_mdio_oe ? dev_mdio_o : (phy_mdio_oe ? phy_mdio_o : 1'b1);

  modport dev (output mdc, output dev_mdio_o, output dev_mdio_oe, input mdio);
  modport phy (input mdc, input mdio, output phy_mdio_o, output phy_mdio_oe);
endinterface

// [ipm_sync2.sv]
// Two-stage synchroniser for levels arriving from outside the pclk domain.
// Assumes the source level is stable for several pclk cycles.
`timescale 1ns/1ps
module ipm_sync2 #(
  parameter int W = 1
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule

// [ipm_dev_end.sv]
// Indirect PHY register access engine: APB slave with data and access
// registers, and a clause 22 management frame master driving the link.
// Assumes software polls the busy flag before touching either register.
//
// Notes on behaviour
// - Access register write starts one management access
// - Data register low 16 bits hold value
// - Host loads data before a write access
// - Read access returns PHY value into data
// - Data read: PHY value if read, else written
// - Bits 15:11 select the target PHY
// - Bits 10:6 select the PHY register
// - Direction bit: 1 write, 0 read
// - Busy sets whenever access register is written (code: only on writes while busy is 0; others are ignored)
// - Busy holds during access, self-clears, not writable
// - Host waits for busy 0 before writing
// - Host keeps data unchanged during write access
// - Data invalid until busy clears on read
// - Emulated PHY unreachable through this path
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module ipm_dev_end
  import ipm_pkg::*;
#(
  parameter logic [4:0] VPHY_ADDR = 5'h00
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ipm_mgmt_if.dev link
);
  typedef enum logic [2:0] {
    ENG_IDLE = 3'h1,
    ENG_SHIFT = 3'h2,
    ENG_DONE = 3'h4
  } ipm_eng_e;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [15:0] wdata_ff;
  logic [15:0] nxt_wdata;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic [4:0] tgt_ff;
  logic [4:0] nxt_tgt;
  logic [4:0] ridx_ff;
  logic [4:0] nxt_ridx;
  logic dir_ff;
  logic nxt_dir;
  logic busy_ff;
  logic nxt_busy;
  ipm_eng_e eng_ff;
  ipm_eng_e nxt_eng;
  logic [7:0] div_ff;
  logic [7:0] nxt_div;
  logic mdc_ff;
  logic nxt_mdc;
  logic [5:0] idx_ff;
  logic [5:0] nxt_idx;
  logic [63:0] frame_ff;
  logic [63:0] nxt_frame;
  logic [15:0] cap_ff;
  logic [15:0] nxt_cap;
  logic mdio_o_ff;
  logic nxt_mdio_o;
  logic mdio_oe_ff;
  logic nxt_mdio_oe;
  logic apb_setup;
  logic apb_take;
  logic start;
  logic eng_done;
  logic mdio_s;
  logic div_wrap;
  logic rise;
  logic fall;
  logic [4:0] new_tgt;
  logic [4:0] new_ridx;
  logic new_dir;
  ipm_sync2 #(.W(1)) u_mdio_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(link.mdio),
    .dout(mdio_s)
  );
  assign apb_setup = psel && !penable;
  assign apb_take = psel && penable && pready_ff;
  assign new_tgt = pwdata[ACC_TGT_LSB +: 5];
  assign new_ridx = pwdata[ACC_RIDX_LSB +: 5];
  assign new_dir = pwdata[ACC_DIR_BIT];
  assign start = apb_take && pwrite && (paddr == OFS_ACCESS) && !busy_ff;
  assign eng_done = (eng_ff == ENG_DONE);
  assign div_wrap = (div_ff == MDC_HALF_LAST);
  assign rise = div_wrap && !mdc_ff;
  assign fall = div_wrap && mdc_ff;
  // Register file and APB slave
  always_comb
  begin
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_tgt = tgt_ff;
    nxt_ridx = ridx_ff;
    nxt_dir = dir_ff;
    nxt_busy = busy_ff;
    if (apb_setup)
    begin
      nxt_pready = 1'b1;
      case (paddr)
        OFS_DATA:
          nxt_prdata = {16'h0000, dir_ff ? wdata_ff : rdata_ff};
        OFS_ACCESS:
          nxt_prdata = {16'h0000, tgt_ff, ridx_ff, 4'h0, dir_ff, busy_ff};
        default:
        begin
          nxt_prdata = 32'h0000_0000;
          nxt_pslverr = 1'b1;
        end
      endcase
    end
    if (apb_take && pwrite && !busy_ff && (paddr == OFS_DATA))
      nxt_wdata = pwdata[15:0];
    if (start)
    begin
      nxt_tgt = new_tgt;
      nxt_ridx = new_ridx;
      nxt_dir = new_dir;
      nxt_busy = 1'b1;
    end
    if (eng_done)
    begin
      nxt_busy = 1'b0;
      if (!dir_ff)
        nxt_rdata = cap_ff;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      wdata_ff <= DATA_RST;
      rdata_ff <= DATA_RST;
      tgt_ff <= TGT_RST;
      ridx_ff <= RIDX_RST;
      dir_ff <= DIR_RST;
      busy_ff <= BUSY_RST;
    end
    else
    begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      tgt_ff <= nxt_tgt;
      ridx_ff <= nxt_ridx;
      dir_ff <= nxt_dir;
      busy_ff <= nxt_busy;
    end
  end
  // Frame engine: bits change on MDC fall, are sampled on MDC rise
  always_comb
  begin
    nxt_eng = eng_ff;
    nxt_div = div_ff;
    nxt_mdc = mdc_ff;
    nxt_idx = idx_ff;
    nxt_frame = frame_ff;
    nxt_cap = cap_ff;
    nxt_mdio_o = mdio_o_ff;
    nxt_mdio_oe = mdio_oe_ff;
    case (eng_ff)
      ENG_IDLE:
      begin
        nxt_div = 8'h00;
        nxt_mdc = 1'b0;
        nxt_mdio_o = 1'b1;
        nxt_mdio_oe = 1'b0;
        if (start)
        begin
          if (new_tgt == VPHY_ADDR)
          begin
            nxt_cap = NO_ANSWER;
            nxt_eng = ENG_DONE;
          end
          else
          begin
            nxt_frame = {PREAMBLE, ST_CODE, new_dir ? OP_WR : OP_RD, new_tgt, new_ridx,
                         new_dir ? TA_WR : TA_RD, new_dir ? wdata_ff : NO_ANSWER};
            nxt_idx = 6'h00;
            nxt_mdio_o = 1'b1;
            nxt_mdio_oe = 1'b1;
            nxt_eng = ENG_SHIFT;
          end
        end
      end
      ENG_SHIFT:
      begin
        nxt_div = div_wrap ? 8'h00 : div_ff + 8'h01;
        if (div_wrap)
          nxt_mdc = !mdc_ff;
        if (rise && !dir_ff && (idx_ff >= IDX_DATA_FIRST))
          nxt_cap = {cap_ff[14:0], mdio_s};
        if (fall)
        begin
          if (idx_ff == IDX_LAST)
          begin
            nxt_mdio_o = 1'b1;
            nxt_mdio_oe = 1'b0;
            nxt_eng = ENG_DONE;
          end
          else
          begin
            nxt_idx = idx_ff + 6'h01;
            nxt_frame = {frame_ff[62:0], 1'b0};
            nxt_mdio_o = frame_ff[62];
            nxt_mdio_oe = dir_ff || ((idx_ff + 6'h01) < IDX_TA_FIRST);
          end
        end
      end
      ENG_DONE:
        nxt_eng = ENG_IDLE;
      default:
        nxt_eng = ENG_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eng_ff <= ENG_IDLE;
      div_ff <= 8'h00;
      mdc_ff <= 1'b0;
      idx_ff <= 6'h00;
      frame_ff <= 64'h0000_0000_0000_0000;
      cap_ff <= DATA_RST;
      mdio_o_ff <= 1'b1;
      mdio_oe_ff <= 1'b0;
    end
    else
    begin
      eng_ff <= nxt_eng;
      div_ff <= nxt_div;
      mdc_ff <= nxt_mdc;
      idx_ff <= nxt_idx;
      frame_ff <= nxt_frame;
      cap_ff <= nxt_cap;
      mdio_o_ff <= nxt_mdio_o;
      mdio_oe_ff <= nxt_mdio_oe;
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign link.mdc = mdc_ff;
  assign link.dev_mdio_o = mdio_o_ff;
  assign link.dev_mdio_oe = mdio_oe_ff;
endmodule

// [ipm_phy_end.sv]
// PHY management register logic: decodes clause 22 frames on the link
// and serves a 32-entry register set at one PHY address.
// Assumes MDC and MDIO come from outside and are synchronised here.
`timescale 1ns/1ps
module ipm_phy_end
  import ipm_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h01
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ld_stb,
  input wire logic [4:0] ld_idx,
  input wire logic [15:0] ld_data,
  output logic upd_stb,
  output logic [4:0] upd_idx,
  output logic [15:0] upd_data,
  ipm_mgmt_if.phy link
);
  typedef enum logic [4:0] {
    PHY_IDLE = 5'h01,
    PHY_ST = 5'h02,
    PHY_HDR = 5'h04,
    PHY_WDAT = 5'h08,
    PHY_RDAT = 5'h10
  } ipm_phy_e;

  logic [15:0] regs_ff [32];
  ipm_phy_e st_ff;
  ipm_phy_e nxt_st;
  logic [5:0] ones_ff;
  logic [5:0] nxt_ones;
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic [15:0] sh_ff;
  logic [15:0] nxt_sh;
  logic [4:0] widx_ff;
  logic [4:0] nxt_widx;
  logic o_ff;
  logic nxt_o;
  logic oe_ff;
  logic nxt_oe;
  logic mdc_d_ff;
  logic upd_stb_ff;
  logic nxt_upd_stb;
  logic [4:0] upd_idx_ff;
  logic [4:0] nxt_upd_idx;
  logic [15:0] upd_data_ff;
  logic [15:0] nxt_upd_data;
  logic mem_we;
  logic [4:0] mem_wa;
  logic [15:0] mem_wd;
  logic [1:0] pins_s;
  logic rise;
  logic bit_s;

  ipm_sync2 #(.W(2)) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({link.mdc, link.mdio}),
    .dout(pins_s)
  );

  assign bit_s = pins_s[0];
  assign rise = pins_s[1] && !mdc_d_ff;

  always_comb
  begin
    logic [11:0] hdr;
    hdr = {sh_ff[10:0], bit_s};
    nxt_st = st_ff;
    nxt_ones = ones_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_widx = widx_ff;
    nxt_o = o_ff;
    nxt_oe = oe_ff;
    nxt_upd_stb = 1'b0;
    nxt_upd_idx = upd_idx_ff;
    nxt_upd_data = upd_data_ff;
    mem_we = ld_stb;
    mem_wa = ld_idx;
    mem_wd = ld_data;
    if (rise)
    begin
      case (st_ff)
        PHY_IDLE:
        begin
          nxt_ones = (ones_ff == PRE_CNT) ? ones_ff : ones_ff + 6'h01;
          if (!bit_s)
          begin
            nxt_ones = 6'h00;
            if (ones_ff == PRE_CNT)
              nxt_st = PHY_ST;
          end
        end
        PHY_ST:
        begin
          nxt_cnt = 6'h00;
          nxt_st = bit_s ? PHY_HDR : PHY_IDLE;
        end
        PHY_HDR:
        begin
          nxt_sh = {sh_ff[14:0], bit_s};
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == HDR_LAST)
          begin
            nxt_cnt = 6'h00;
            nxt_st = PHY_IDLE;
            nxt_widx = hdr[4:0];
            if (hdr[9:5] == PHY_ADDR && hdr[11:10] == OP_WR)
              nxt_st = PHY_WDAT;
            if (hdr[9:5] == PHY_ADDR && hdr[11:10] == OP_RD)
            begin
              nxt_sh = regs_ff[hdr[4:0]];
              nxt_st = PHY_RDAT;
            end
          end
        end
        PHY_WDAT:
        begin
          nxt_sh = {sh_ff[14:0], bit_s};
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == TAIL_LAST)
          begin
            mem_we = 1'b1;
            mem_wa = widx_ff;
            mem_wd = {sh_ff[14:0], bit_s};
            nxt_upd_stb = 1'b1;
            nxt_upd_idx = widx_ff;
            nxt_upd_data = {sh_ff[14:0], bit_s};
            nxt_st = PHY_IDLE;
          end
        end
        PHY_RDAT:
        begin
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == 6'h00)
          begin
            nxt_oe = 1'b1;
            nxt_o = 1'b0;
          end
          else if (cnt_ff == TAIL_LAST)
          begin
            nxt_oe = 1'b0;
            nxt_o = 1'b1;
            nxt_st = PHY_IDLE;
          end
          else
          begin
            nxt_o = sh_ff[15];
            nxt_sh = {sh_ff[14:0], 1'b0};
          end
        end
        default:
          nxt_st = PHY_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 32; i++)
        regs_ff[i] <= 16'h0000;
      st_ff <= PHY_IDLE;
      ones_ff <= 6'h00;
      cnt_ff <= 6'h00;
      sh_ff <= 16'h0000;
      widx_ff <= 5'h00;
      o_ff <= 1'b1;
      oe_ff <= 1'b0;
      mdc_d_ff <= 1'b0;
      upd_stb_ff <= 1'b0;
      upd_idx_ff <= 5'h00;
      upd_data_ff <= 16'h0000;
    end
    else
    begin
      if (mem_we)
        regs_ff[mem_wa] <= mem_wd;
      st_ff <= nxt_st;
      ones_ff <= nxt_ones;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      widx_ff <= nxt_widx;
      o_ff <= nxt_o;
      oe_ff <= nxt_oe;
      mdc_d_ff <= pins_s[1];
      upd_stb_ff <= nxt_upd_stb;
      upd_idx_ff <= nxt_upd_idx;
      upd_data_ff <= nxt_upd_data;
    end
  end

  assign upd_stb = upd_stb_ff;
  assign upd_idx = upd_idx_ff;
  assign upd_data = upd_data_ff;
  assign link.phy_mdio_o = o_ff;
  assign link.phy_mdio_oe = oe_ff;
endmodule

// [ipm_link_props.sv]
// Checker for the management link between the access engine and the PHY end.
// Assumes the signals of one ipm_mgmt_if, all in the pclk domain.
`timescale 1ns/1ps
module ipm_link_props
  import ipm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mdc,
  input wire logic dev_mdio_o,
  input wire logic dev_mdio_oe,
  input wire logic phy_mdio_o,
  input wire logic phy_mdio_oe
);
  logic mdc_ff;
  logic oe_ff;
  logic [7:0] hi_cnt_ff;
  logic [6:0] fr_cnt_ff;
  logic [7:0] nxt_hi_cnt;
  logic [6:0] nxt_fr_cnt;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Clock high time, and clock rises since the frame began
  always_comb
  begin
    nxt_hi_cnt = mdc ? hi_cnt_ff + 8'h01 : 8'h00;
    nxt_fr_cnt = fr_cnt_ff;
    if (dev_mdio_oe && !oe_ff)
      nxt_fr_cnt = 7'h00;
    else if (mdc && !mdc_ff)
      nxt_fr_cnt = fr_cnt_ff + 7'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mdc_ff <= 1'b0;
      oe_ff <= 1'b0;
      hi_cnt_ff <= 8'h00;
      fr_cnt_ff <= 7'h00;
    end
    else
    begin
      mdc_ff <= mdc;
      oe_ff <= dev_mdio_oe;
      hi_cnt_ff <= nxt_hi_cnt;
      fr_cnt_ff <= nxt_fr_cnt;
    end
  end

  sequence s_start;
    $rose(dev_mdio_oe);
  endsequence
  sequence s_phy_on;
    $rose(phy_mdio_oe);
  endsequence

  property p_mdc_high;
    $fell(mdc) |-> hi_cnt_ff == MDC_HALF_CYC;
  endproperty
  a_mdc_high: assert property (p_mdc_high) else $error("mdc high time wrong");
  property p_hold;
    dev_mdio_oe && mdc |-> $stable(dev_mdio_o);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved while mdc high");
  property p_start;
    s_start |-> dev_mdio_o && !mdc;
  endproperty
  a_start: assert property (p_start) else $error("frame start wrong");
  property p_no_clash;
    !(dev_mdio_oe && phy_mdio_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive");
  property p_dev_release;
    $fell(dev_mdio_oe) |-> fr_cnt_ff == 46 || fr_cnt_ff == 64;
  endproperty
  a_dev_release: assert property (p_dev_release) else $error("release bit wrong");
  property p_phy_on;
    s_phy_on |-> fr_cnt_ff == 47 && !dev_mdio_oe;
  endproperty
  a_phy_on: assert property (p_phy_on) else $error("phy drive start wrong");
  property p_phy_ta;
    s_phy_on |-> !phy_mdio_o ##1 phy_mdio_oe;
  endproperty
  a_phy_ta: assert property (p_phy_ta) else $error("turnaround not zero");
  property p_phy_off;
    $fell(phy_mdio_oe) |-> fr_cnt_ff == 64;
  endproperty
  a_phy_off: assert property (p_phy_off) else $error("phy release wrong");
endmodule

// [indirect_phy_register_access_tb.sv]
// Testbench: APB host on the access engine, PHY register logic on the link.
// Assumes both ends share pclk and the pull-up inside ipm_mgmt_if.
`timescale 1ns/1ps
module indirect_phy_register_access_tb;
  import ipm_pkg::*;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, err_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ld_stb, upd_stb, mdc_q;
  logic [4:0] ld_idx, upd_idx, upd_i;
  logic [15:0] ld_data, upd_data, upd_d;
  logic [63:0] frame;
  int err_total, compares, upd_n;

  ipm_mgmt_if lk();
  ipm_dev_end #(.VPHY_ADDR(5'h00)) u_ipm_dev_end (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lk));
  ipm_phy_end #(.PHY_ADDR(5'h01)) u_ipm_phy_end (.pclk(pclk), .presetn(presetn),
    .ld_stb(ld_stb), .ld_idx(ld_idx), .ld_data(ld_data), .upd_stb(upd_stb),
    .upd_idx(upd_idx), .upd_data(upd_data), .link(lk));
  ipm_link_props u_ipm_link_props (.pclk(pclk), .presetn(presetn), .mdc(lk.mdc),
    .dev_mdio_o(lk.dev_mdio_o), .dev_mdio_oe(lk.dev_mdio_oe),
    .phy_mdio_o(lk.phy_mdio_o), .phy_mdio_oe(lk.phy_mdio_oe));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Wire bits at each mdc rise, frame writes seen
  always @(posedge pclk)
  begin
    mdc_q <= lk.mdc;
    if (lk.mdc === 1'b1 && mdc_q === 1'b0)
      frame <= {frame[62:0], lk.mdio};
    if (upd_stb === 1'b1)
    begin
      upd_n++;
      upd_i = upd_idx;
      upd_d = upd_data;
    end
  end

  task automatic final_report();
    $display("counts: compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // One access with junk in reserved bits and busy bit written 0; ends with data read
  task automatic access(input logic [4:0] tgt, input logic [4:0] idx, input logic dir);
    int n;
    n = 0;
    apb(1'b1, OFS_ACCESS, {16'hffff, tgt, idx, 4'hf, dir, 1'b0});
    if (tgt != 5'h00)
    begin
      apb(1'b0, OFS_ACCESS, 32'h0000_0000);
      chk("busy", rd, {16'h0000, tgt, idx, 4'h0, dir, 1'b1});
      apb(1'b1, OFS_DATA, 32'h0000_1111);
      apb(1'b1, OFS_ACCESS, {16'h0000, tgt, 5'h03, 4'h0, ~dir, 1'b0});
    end
    do
    begin
      apb(1'b0, OFS_ACCESS, 32'h0000_0000);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 3000);
    chk("idle", rd, {16'h0000, tgt, idx, 4'h0, dir, 1'b0});
    apb(1'b0, OFS_DATA, 32'h0000_0000);
  endtask

  task automatic run_tests();
    {presetn, psel, penable, pwrite, ld_stb} = 5'h00;
    {paddr, pwdata, ld_idx, ld_data} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    ld_stb <= 1'b1;
    ld_idx <= 5'h05;
    ld_data <= 16'h1234;
    @(posedge pclk);
    ld_stb <= 1'b0;
    apb(1'b0, OFS_DATA, 32'h0000_0000);
    chk("data reset", rd, 32'h0000_0000);
    apb(1'b0, OFS_ACCESS, 32'h0000_0000);
    chk("access reset", rd, 32'h0000_0000);
    apb(1'b0, 12'h0b0, 32'h0000_0000);
    chk("unmapped err", {31'h0000_0000, err_seen}, 32'h0000_0001);
    access(5'h01, 5'h05, 1'b0);
    chk("read data", rd, 32'h0000_1234);
    chk("read preamble", frame[63:32], PREAMBLE);
    chk("read header", {18'h0_0000, frame[31:18]}, {18'h0_0000, ST_CODE, OP_RD, 5'h01, 5'h05});
    apb(1'b1, OFS_DATA, 32'hffff_a5c3);
    apb(1'b0, OFS_DATA, 32'h0000_0000);
    chk("data dir0", rd, 32'h0000_1234);
    access(5'h01, 5'h09, 1'b1);
    chk("data dir1", rd, 32'h0000_a5c3);
    chk("write frame", frame[31:0], {ST_CODE, OP_WR, 5'h01, 5'h09, TA_WR, 16'ha5c3});
    chk("write count", upd_n, 32'h0000_0001);
    chk("write dest", {11'h000, upd_i, upd_d}, {11'h000, 5'h09, 16'ha5c3});
    access(5'h01, 5'h09, 1'b0);
    chk("read back", rd, 32'h0000_a5c3);
    access(5'h00, 5'h05, 1'b0);
    chk("emulated refused", rd, 32'h0000_ffff);
    access(5'h02, 5'h05, 1'b0);
    chk("other target", rd, 32'h0000_ffff);
    chk("no extra writes", upd_n, 32'h0000_0001);
  endtask

  // Tests race a cycle ceiling; either way the report ends the run
  initial
  begin
    fork
      run_tests();
      begin
        repeat (60000) @(posedge pclk);
        err_total++;
      end
    join_any
    final_report();
  end
endmodule
